// ### input_one_pkg.sv
// Purpose: Shared constants for the control input one configuration block
// Assumes: APB with 32-bit data; one aligned word per register
// Notes:   Switch bit n of the switchgroup sits at bit position n-1
package input_one_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_OFFSET    = 8'h00;
    localparam logic [7:0] BANK_OFFSET   = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic       BANK_RESET    = 1'b0;
    // ------------------------------------------------------------
    // Switchgroup field positions
    // ------------------------------------------------------------
    localparam int SW_BLOCK_LOW_OC  = 0;
    localparam int SW_BLOCK_HIGH_OC = 1;
    localparam int SW_BLOCK_LOW_EF  = 2;
    localparam int SW_BLOCK_HIGH_EF = 3;
    localparam int SW_BANK_BY_INPUT = 4;
    localparam int SW_LATCH_OC      = 5;
    localparam int SW_LATCH_EF      = 6;
    localparam int SW_REMOTE_RESET  = 7;
    // ------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------
    localparam int ST_BLOCK_LSB   = 0;
    localparam int ST_SECOND_BANK = 4;
    localparam int ST_OC_LATCH    = 5;
    localparam int ST_EF_LATCH    = 6;
    localparam int ST_TRIP        = 7;
    localparam int ST_INPUT_LEVEL = 8;
    localparam int STAGE_COUNT    = 4;
endpackage

// ### control_input_one_config_logic.sv
// Purpose: Configuration logic for control input one of a feeder protection
//          module: stage blocking, setting bank choice, trip latching, reset
// Assumes: Pins and pushbuttons are asynchronous; stage operate signals and
//          panel bank requests come from logic on core_clk
//          Switch 5 is kept equal in both setting banks by the user
// Notes:   Registers answer over APB with one wait-free access phase
//          Blocked stages neither trip nor latch; set wins over clear
//
// Behaviour
// - Switch 1 set: input one asserted blocks the low-set overcurrent stage.
// - Switch 2 set: input one asserted blocks the high-set overcurrent stage.
// - Switch 3 set: input one asserted blocks the low-set earth-fault stage.
// - Switch 4 set: input one asserted blocks the high-set earth-fault stage.
// - Switches 1 to 4 clear: input one blocks no stage.
// - Switch 5 clear: bank follows stored choice from serial command or buttons.
// - Switch 5 set: input low selects main bank, input high second bank.
// - Switch 5 set: serial and pushbutton bank selections are rejected.
// - Switch 6 clear: overcurrent trip releases when the stage resets.
// - Switch 6 set: overcurrent trip held until reset and step pressed together.
// - Switch 7 clear: earth-fault trip releases when the stage resets.
// - Switch 7 set: earth-fault trip held until reset and step pressed together.
// - Assertion of input one also clears latched trips.
// - Display off: step button alone also clears latched trips.
// - Switch 8 set: input one assertion performs a complete relay reset.
module control_input_one_config_logic
    import input_one_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   srst,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Pins and front panel
    input  wire logic                   controlInputOne,
    input  wire logic                   resetButton,
    input  wire logic                   stepButton,
    input  wire logic                   displayOn,
    input  wire logic                   panelBankReq,
    input  wire logic                   panelBankSecond,
    // Protection stages: low OC, high OC, low EF, high EF
    input  wire logic [STAGE_COUNT-1:0] stageOperate,
    output logic      [STAGE_COUNT-1:0] stageBlock,
    output logic                        secondBankActive,
    output logic                        tripOutputTwo,
    output logic                        completeReset
);
    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    // Two flops per pin keep metastability away from the decode; the third
    // stage only remembers the last level for edge detection, so level effects
    // land two cycles after the pin moves and registered effects three
    logic [3:0] syncA_reg;
    logic [3:0] syncB_reg;
    logic [3:0] prev_reg;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            syncA_reg <= 4'h0;
            syncB_reg <= 4'h0;
            prev_reg  <= 4'h0;
        end else begin
            syncA_reg <= {displayOn, stepButton, resetButton, controlInputOne};
            syncB_reg <= syncA_reg;
            prev_reg  <= syncB_reg;
        end
    end

    wire inputLevel  = syncB_reg[0];
    wire resetLevel  = syncB_reg[1];
    wire stepLevel   = syncB_reg[2];
    wire displayLvl  = syncB_reg[3];
    // Rises last one cycle; prev_reg resets low like the idle pins
    wire inputRise   = syncB_reg[0] & ~prev_reg[0];
    wire resetRise   = syncB_reg[1] & ~prev_reg[1];
    wire stepRise    = syncB_reg[2] & ~prev_reg[2];

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    logic [7:0]  cfg_reg;
    logic        bank_reg;
    logic        ocLatch_reg;
    logic        efLatch_reg;

    wire setupPhase = psel & ~penable;
    wire hitCfg     = (paddr == CFG_OFFSET);
    wire hitBank    = (paddr == BANK_OFFSET);
    wire hitStatus  = (paddr == STATUS_OFFSET);
    wire mapped     = hitCfg | hitBank | hitStatus;
    wire writeDone  = psel & penable & pwrite & mapped;
    wire bankByPin  = cfg_reg[SW_BANK_BY_INPUT];

    // No wait states; unmapped offsets answer with an error and read zero
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Software writes to the bank register are the serial bank command
    wire serialBankWr = writeDone & hitBank & ~bankByPin;
    wire panelBankWr  = panelBankReq & ~bankByPin;

    logic bank_next;
    // A serial command beats a panel request in the same cycle
    always_comb begin
        bank_next = bank_reg;
        if (serialBankWr) begin
            bank_next = pwdata[0];
        end else if (panelBankWr) begin
            bank_next = panelBankSecond;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_reg  <= CFG_RESET;
            bank_reg <= BANK_RESET;
        end else begin
            if (writeDone & hitCfg) begin
                cfg_reg <= pwdata[7:0];
            end
            bank_reg <= bank_next;
        end
    end

    // ------------------------------------------------------------
    // Stage blocking
    // ------------------------------------------------------------
    // Blocking is a level and drops two cycles after the pin does
    genvar g;
    generate
        for (g = 0; g < STAGE_COUNT; g++) begin : gBlock
            // Only switches 1 to 4 reach a stage; all clear blocks nothing
            assign stageBlock[g] = cfg_reg[SW_BLOCK_LOW_OC + g] & inputLevel;
        end
    endgenerate

    // ------------------------------------------------------------
    // Setting bank
    // ------------------------------------------------------------
    // Pin control overrides the stored choice but leaves it untouched, so
    // clearing switch 5 brings back the last accepted selection
    assign secondBankActive = bankByPin ? inputLevel : bank_reg;

    // ------------------------------------------------------------
    // Trip latching and resets
    // ------------------------------------------------------------
    // A blocked stage neither trips nor sets a latch
    wire [STAGE_COUNT-1:0] effOperate = stageOperate & ~stageBlock;
    wire ocOperate   = effOperate[0] | effOperate[1];
    wire efOperate   = effOperate[2] | effOperate[3];
    // Both buttons held, caught on whichever edge completes the pair
    wire manualReset = (resetRise & stepLevel) | (stepRise & resetLevel);
    wire stepAlone   = stepRise & ~resetLevel & ~displayLvl;
    wire remoteReset = inputRise & cfg_reg[SW_REMOTE_RESET];
    wire latchClear  = manualReset | stepAlone | inputRise | remoteReset;

    // Set wins over clear so a trip arriving with a reset is never lost
    wire ocLatch_next = (ocOperate & cfg_reg[SW_LATCH_OC]) | (ocLatch_reg & ~latchClear);
    wire efLatch_next = (efOperate & cfg_reg[SW_LATCH_EF]) | (efLatch_reg & ~latchClear);

    // Registered so the trip pin never carries a decode glitch
    logic tripOutputTwo_reg;
    logic completeReset_reg;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ocLatch_reg       <= 1'b0;
            efLatch_reg       <= 1'b0;
            tripOutputTwo_reg <= 1'b0;
            completeReset_reg <= 1'b0;
        end else begin
            ocLatch_reg       <= ocLatch_next;
            efLatch_reg       <= efLatch_next;
            tripOutputTwo_reg <= ocOperate | efOperate | ocLatch_next | efLatch_next;
            completeReset_reg <= remoteReset;
        end
    end
    assign tripOutputTwo = tripOutputTwo_reg;
    assign completeReset = completeReset_reg;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire [31:0] statusWord = {23'h0, inputLevel, tripOutputTwo_reg, efLatch_reg,
                              ocLatch_reg, secondBankActive, stageBlock};
    wire [31:0] readMux = hitCfg  ? {24'h0, cfg_reg} :
                          hitBank ? {31'h0, bank_reg} :
                          hitStatus ? statusWord : 32'h0;

    // Captured in the setup cycle so it stays settled through the access
    // phase; status bits are a snapshot of that cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            prdata <= 32'h0;
        end else if (setupPhase & ~pwrite) begin
            prdata <= readMux;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // Properties watch the synchronised pins, never the raw ones

    sequence inputRiseSeq;
        !syncB_reg[0] ##1 syncB_reg[0];
    endsequence

    // Reset button rises while step is already held
    sequence resetPairSeq;
        !syncB_reg[1] ##1 (syncB_reg[1] && syncB_reg[2]);
    endsequence

    // Step button rises while reset is already held
    sequence stepPairSeq;
        !syncB_reg[2] ##1 (syncB_reg[2] && syncB_reg[1]);
    endsequence

    // ------------------------------------------------------------
    // Stage blocking
    // ------------------------------------------------------------

    low_oc_block_a: assert property (cfg_reg[0] && inputLevel |-> stageBlock[0])
        else $error("low-set overcurrent not blocked");
    high_oc_block_a: assert property (cfg_reg[1] && inputLevel |-> stageBlock[1])
        else $error("high-set overcurrent not blocked");
    low_ef_block_a: assert property (cfg_reg[2] && inputLevel |-> stageBlock[2])
        else $error("low-set earth fault not blocked");
    high_ef_block_a: assert property (cfg_reg[3] && inputLevel |-> stageBlock[3])
        else $error("high-set earth fault not blocked");
    no_block_a: assert property (cfg_reg[3:0] == 4'h0 |-> stageBlock == 4'h0)
        else $error("stage blocked with switches clear");

    // ------------------------------------------------------------
    // Setting bank
    // ------------------------------------------------------------
    // Pin control must leave the stored choice alone
    pin_bank_a: assert property (bankByPin |-> secondBankActive == syncB_reg[0])
        else $error("bank does not follow input level");
    bank_reject_a: assert property (bankByPin && !(writeDone && hitCfg) |=> $stable(bank_reg))
        else $error("bank selection accepted while pin controlled");
    stored_bank_a: assert property (!bankByPin |-> secondBankActive == bank_reg)
        else $error("bank ignores stored selection");
    serial_bank_a: assert property (!bankByPin && writeDone && hitBank |=> bank_reg == $past(pwdata[0]))
        else $error("serial bank command not taken");
    panel_bank_a: assert property (!bankByPin && panelBankReq && !(writeDone && hitBank)
                                   |=> bank_reg == $past(panelBankSecond))
        else $error("panel bank request not taken");

    // ------------------------------------------------------------
    // Trip latching
    // ------------------------------------------------------------
    oc_release_a: assert property (!cfg_reg[5] && !ocLatch_reg && !efOperate && !efLatch_reg
                                   && !ocOperate |=> !tripOutputTwo)
        else $error("overcurrent trip not released");
    oc_hold_a: assert property (
        cfg_reg[5] && ocOperate |=> ocLatch_reg ##1 (ocLatch_reg || $past(latchClear)))
        else $error("overcurrent trip not held");
    ef_hold_a: assert property (cfg_reg[6] && efOperate |=> efLatch_reg)
        else $error("earth-fault trip not held");
    ef_release_a: assert property (!cfg_reg[6] && !efOperate |=> !efLatch_reg || $past(efLatch_reg))
        else $error("earth-fault latch set without switch");
    oc_free_a: assert property (!cfg_reg[5] |=> !ocLatch_reg || $past(ocLatch_reg))
        else $error("overcurrent latch set without switch");
    trip_follow_a: assert property (ocOperate || efOperate |=> tripOutputTwo)
        else $error("trip output missing while a stage operates");
    // Latches only fall through a clear; nothing else may drop them
    oc_keep_a: assert property (ocLatch_reg && !latchClear |=> ocLatch_reg)
        else $error("overcurrent latch dropped without reset");
    ef_keep_a: assert property (efLatch_reg && !latchClear |=> efLatch_reg)
        else $error("earth-fault latch dropped without reset");

    // ------------------------------------------------------------
    // Latch clearing and complete reset
    // ------------------------------------------------------------
    input_clear_a: assert property (inputRiseSeq ##0 !ocOperate |=> !ocLatch_reg)
        else $error("input did not clear latched trip");
    step_clear_a: assert property (stepAlone && !efOperate |=> !efLatch_reg)
        else $error("step alone did not clear latched trip");
    remote_reset_a: assert property (inputRiseSeq ##0 cfg_reg[7] |=> completeReset ##1 !completeReset)
        else $error("complete reset pulse missing");
    reset_pair_a: assert property (resetPairSeq ##0 !ocOperate && !efOperate
                                   |=> !ocLatch_reg && !efLatch_reg)
        else $error("button pair did not clear latches");
    step_pair_a: assert property (stepPairSeq ##0 !ocOperate && !efOperate
                                  |=> !ocLatch_reg && !efLatch_reg)
        else $error("button pair did not clear latches");
    ef_input_clear_a: assert property (inputRiseSeq ##0 !efOperate |=> !efLatch_reg)
        else $error("input did not clear earth-fault latch");
    oc_step_clear_a: assert property (stepAlone && !ocOperate |=> !ocLatch_reg)
        else $error("step alone did not clear overcurrent latch");
    no_remote_a: assert property (!cfg_reg[7] |=> !completeReset)
        else $error("complete reset without switch 8");
endmodule

// ### panel_wiring_model.sv
// Purpose: Far side of the block: control wiring on input one and panel buttons
// Assumes: Bench asks for pin levels; the model moves them just after an edge
// Notes:   Pins are plain levels with no bounce, so effects show at fixed counts
module panel_wiring_model (
    input  wire logic core_clk,
    input  wire logic wantInput,
    input  wire logic wantReset,
    input  wire logic wantStep,
    output logic      controlInputOne,
    output logic      resetButton,
    output logic      stepButton
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge core_clk) begin
        controlInputOne <= wantInput;
        resetButton     <= wantReset;
        stepButton      <= wantStep;
    end
endmodule

// ### test_control_input_one_config_logic.sv
// Purpose: Self-checking bench for the control input one configuration block
// Assumes: APB answers without wait states, yet every wait stays bounded
// Notes: Switchgroup values keep bank-by-input alone in use
module test_control_input_one_config_logic
    import input_one_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, srst, psel, penable, pwrite, pready, pslverr, rdErr;
    logic        displayOn, panelBankReq, panelBankSecond, wantInput, wantReset, wantStep;
    logic        controlInputOne, resetButton, stepButton, secondBankActive, tripOutputTwo, completeReset;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  stageOperate, stageBlock;
    int          errTotal, nChecks, pulses;
    control_input_one_config_logic uut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .controlInputOne(controlInputOne), .resetButton(resetButton), .stepButton(stepButton),
        .displayOn(displayOn), .panelBankReq(panelBankReq), .panelBankSecond(panelBankSecond),
        .stageOperate(stageOperate), .stageBlock(stageBlock), .secondBankActive(secondBankActive),
        .tripOutputTwo(tripOutputTwo), .completeReset(completeReset));
    panel_wiring_model far (.core_clk(core_clk), .wantInput(wantInput), .wantReset(wantReset),
        .wantStep(wantStep), .controlInputOne(controlInputOne), .resetButton(resetButton),
        .stepButton(stepButton));
    initial begin
        core_clk = 0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (completeReset === 1'b1) pulses++;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin errTotal++; final_report(); end
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic pin(input logic i, input logic r, input logic s);
        @(posedge core_clk);
        wantInput <= i; wantReset <= r; wantStep <= s;
        cyc(6);
    endtask
    task automatic op(input int i, input logic held);
        @(posedge core_clk) stageOperate <= 4'h1 << i;
        cyc(2);
        chk(tripOutputTwo, 1'b1);
        @(posedge core_clk) stageOperate <= 4'h0;
        cyc(3);
        chk(tripOutputTwo, held);
    endtask
    task automatic panel(input logic s);
        @(posedge core_clk) begin panelBankReq <= 1'b1; panelBankSecond <= s; end
        @(posedge core_clk) panelBankReq <= 1'b0;
        cyc(2);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        apb(0, CFG_OFFSET, 0);  chk(rd, {24'h0, CFG_RESET});
        apb(0, BANK_OFFSET, 0); chk(rd, {31'h0, BANK_RESET});
        apb(1, CFG_OFFSET, 32'h000000A5);
        apb(0, CFG_OFFSET, 0);  chk(rd, 32'h000000A5);
        apb(0, 8'h0C, 0);       chk(rd, 0); chk(rdErr, 1'b1);
        $display("t_regs done");
    endtask
    task automatic t_block();
        for (int i = 0; i < 4; i++) begin
            apb(1, CFG_OFFSET, 32'h1 << i);
            pin(1, 0, 0); chk(stageBlock, 4'h1 << i);
            @(posedge core_clk) stageOperate <= 4'h1 << i;
            cyc(3); chk(tripOutputTwo, 1'b0);
            @(posedge core_clk) stageOperate <= 4'h0;
            pin(0, 0, 0); chk(stageBlock, 4'h0);
        end
        apb(1, CFG_OFFSET, 0);
        pin(1, 0, 0); chk(stageBlock, 4'h0);
        pin(0, 0, 0);
        $display("t_block done");
    endtask
    task automatic t_bank();
        apb(1, BANK_OFFSET, 1); cyc(2); chk(secondBankActive, 1'b1);
        panel(0);               chk(secondBankActive, 1'b0);
        apb(1, CFG_OFFSET, 32'h10); cyc(2); chk(secondBankActive, 1'b0);
        apb(1, BANK_OFFSET, 1); panel(1);   chk(secondBankActive, 1'b0);
        pin(1, 0, 0);           chk(secondBankActive, 1'b1);
        pin(0, 0, 0);
        apb(1, CFG_OFFSET, 0); cyc(2); chk(secondBankActive, 1'b0);
        $display("t_bank done");
    endtask
    task automatic t_latch();
        op(0, 0); op(2, 0);
        apb(1, CFG_OFFSET, 32'h20);
        op(2, 0); op(1, 1);
        apb(0, STATUS_OFFSET, 0); chk(rd, (32'h1 << ST_TRIP) | (32'h1 << ST_OC_LATCH));
        pin(0, 1, 1); chk(tripOutputTwo, 1'b0);
        pin(0, 0, 0);
        apb(1, CFG_OFFSET, 32'h40);
        op(3, 1);
        pin(1, 0, 0); chk(tripOutputTwo, 1'b0);
        pin(0, 0, 0);
        op(2, 1);
        pin(0, 0, 1); chk(tripOutputTwo, 1'b1);
        pin(0, 0, 0);
        displayOn <= 1'b0;
        pin(0, 0, 1); chk(tripOutputTwo, 1'b0);
        pin(0, 0, 0);
        displayOn <= 1'b1;
        $display("t_latch done");
    endtask
    task automatic t_remote();
        pulses = 0;
        apb(1, CFG_OFFSET, 32'h80);
        pin(1, 0, 0); cyc(2); chk(pulses, 1);
        pin(0, 0, 0);
        apb(1, CFG_OFFSET, 0);
        pin(1, 0, 0); cyc(2); chk(pulses, 1);
        pin(0, 0, 0);
        $display("t_remote done");
    endtask
    initial begin
        srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        displayOn = 1; panelBankReq = 0; panelBankSecond = 0; stageOperate = 0;
        wantInput = 0; wantReset = 0; wantStep = 0; errTotal = 0; nChecks = 0; pulses = 0;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        t_regs();
        t_block();
        t_bank();
        t_latch();
        t_remote();
        final_report();
    end
endmodule
